//--- common/cbu_cfg.svh
// Constants for the conditional branch unit
`ifndef CBU_CFG_SVH
`define CBU_CFG_SVH
`define CBU_OPC_HI_ZERO 8'hf6
`define CBU_OPC_HI_OVF 8'hf0
`define CBU_IND_BIT 7
`define CBU_PTR_UPD_BIT 3
`define CBU_MOD_LSB 4
`define CBU_PC_STEP 16'h0002
`define CBU_CYC_BASE 4'h2
`define CBU_CYC_ROM 4'h3
`define CBU_WAIT_DEF 4'h1
`endif

//--- common/cbu_pkg.sv
// Types for the conditional branch unit
package cbu_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXEC = 2'b11
  } cbu_state_t;
  typedef enum logic [1:0] {
    MEM_RAM = 2'b00,
    MEM_ROM = 2'b01,
    MEM_EXT = 2'b10
  } mem_kind_t;
endpackage

//--- rtl/conditional_branch_unit.sv
// Execution logic for the two conditional branch instructions
`timescale 1ns/1ps
`include "cbu_cfg.svh"
module conditional_branch_unit import cbu_pkg::*; #(
  // Extra cycles an external target costs over a ROM target; must keep the count within four bits
  parameter logic [3:0] EXT_WAIT = `CBU_WAIT_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction fetch
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] target_word,
  input wire logic repeat_active,
  input wire logic [1:0] target_kind,
  // Core state
  input wire logic [15:0] pc_in,
  input wire logic [31:0] accumulator,
  input wire logic overflow_flag,
  input wire logic [2:0] aux_reg_pointer,
  input wire logic [15:0] aux_register,
  // Results
  output logic busy,
  output logic done,
  output logic illegal_repeat,
  output logic pc_load,
  output logic [15:0] pc_out,
  output logic taken,
  output logic ovf_clear,
  output logic aux_write,
  output logic [15:0] aux_out,
  output logic [2:0] aux_sel,
  output logic ptr_write,
  output logic [2:0] ptr_out
);
  // State, wait counter and the next value of every registered output
  cbu_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic busy_d, done_d, ill_d, pcl_d, tk_d, ovc_d, arw_d, arpw_d;
  logic [15:0] pc_d, aux_d;
  logic [2:0] sel_d, ptr_d;
  logic is_zero, is_ovf, cond;
  logic [2:0] modf;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Opcode sits in the high byte; the low byte carries the indirect fields
  assign is_zero = instr_word[15:8] == `CBU_OPC_HI_ZERO;
  assign is_ovf = instr_word[15:8] == `CBU_OPC_HI_OVF;
  assign cond = is_zero ? (accumulator == 32'h0000_0000) : overflow_flag;
  assign modf = instr_word[`CBU_MOD_LSB+2:`CBU_MOD_LSB];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Next-state logic; pulse outputs last one cycle
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = busy;
    done_d = 1'b0;
    ill_d = 1'b0;
    pcl_d = 1'b0;
    tk_d = taken;
    ovc_d = 1'b0;
    arw_d = 1'b0;
    arpw_d = 1'b0;
    pc_d = pc_out;
    aux_d = aux_out;
    sel_d = aux_sel;
    ptr_d = ptr_out;
    unique case (state_q)
      ST_IDLE: begin
        if (instr_valid && (is_zero || is_ovf)) begin
          if (repeat_active) begin
            ill_d = 1'b1;
          end else begin
            busy_d = 1'b1;
            tk_d = cond;
            // Target taken whole from the second word, any 16-bit value
            pc_d = cond ? target_word : 16'(pc_in + `CBU_PC_STEP);
            ovc_d = is_ovf && cond;
            // Indirect fields: only act when the indirect bit is set; empty fields leave both alone
            if (instr_word[`CBU_IND_BIT] && modf != 3'h0) begin
              arw_d = 1'b1;
              sel_d = aux_reg_pointer;
              unique case (modf)
                3'h1: aux_d = 16'(aux_register - 16'h0001);
                3'h2: aux_d = 16'(aux_register + 16'h0001);
                default: aux_d = aux_register;
              endcase
            end
            if (instr_word[`CBU_IND_BIT] && instr_word[`CBU_PTR_UPD_BIT]) begin
              arpw_d = 1'b1;
              ptr_d = instr_word[2:0];
            end
            // Extra cycles when taken into ROM or external memory
            if (!cond || target_kind == MEM_RAM) cnt_d = 4'(`CBU_CYC_BASE - 4'h1);
            else if (target_kind == MEM_ROM) cnt_d = 4'(`CBU_CYC_ROM - 4'h1);
            else cnt_d = 4'(`CBU_CYC_ROM - 4'h1 + EXT_WAIT);
            state_d = ST_WAIT;
          end
        end
      end
      // Count down to one; the load strobe follows one execute cycle later
      ST_WAIT: begin
        cnt_d = 4'(cnt_q - 4'h1);
        if (cnt_q == 4'h1) state_d = ST_EXEC;
      end
      // Hand the result over; idle again in the cycle that shows done
      ST_EXEC: begin
        pcl_d = 1'b1;
        done_d = 1'b1;
        busy_d = 1'b0;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Plain flops only, so every output comes straight from a register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      illegal_repeat <= 1'b0;
      pc_load <= 1'b0;
      pc_out <= 16'h0000;
      taken <= 1'b0;
      ovf_clear <= 1'b0;
      aux_write <= 1'b0;
      aux_out <= 16'h0000;
      aux_sel <= 3'h0;
      ptr_write <= 1'b0;
      ptr_out <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy <= busy_d;
      done <= done_d;
      illegal_repeat <= ill_d;
      pc_load <= pcl_d;
      pc_out <= pc_d;
      taken <= tk_d;
      ovf_clear <= ovc_d;
      aux_write <= arw_d;
      aux_out <= aux_d;
      aux_sel <= sel_d;
      ptr_write <= arpw_d;
      ptr_out <= ptr_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // An accepted branch: idle, valid, a branch opcode and not under repeat
  sequence s_start;
    state_q == ST_IDLE && instr_valid && (is_zero || is_ovf) && !repeat_active;
  endsequence
  // Two quiet cycles, then the load strobe with done while busy drops
  sequence s_finish_short;
    !pc_load [*2] ##1 (pc_load && done && !busy);
  endsequence
  // One more quiet cycle when a taken branch lands in ROM
  sequence s_finish_rom;
    !pc_load [*3] ##1 (pc_load && done && !busy);
  endsequence
  // Program counter result
  AST_NOT_TAKEN_STEP: assert property (@(posedge clk) disable iff (rst)
    (s_start and !cond) |=> pc_out == 16'($past(pc_in) + `CBU_PC_STEP)) else $error("pc step wrong");
  AST_TAKEN_TARGET: assert property (@(posedge clk) disable iff (rst)
    (s_start and cond) |=> pc_out == $past(target_word)) else $error("target wrong");
  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (rst)
    busy |=> $stable(pc_out) && $stable(aux_out) && $stable(ptr_out)) else $error("result moved while busy");
  // Overflow flag
  AST_OVF_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (s_start and is_ovf and overflow_flag) |=> ovf_clear) else $error("overflow not cleared");
  AST_OVF_KEEP: assert property (@(posedge clk) disable iff (rst)
    (s_start and is_ovf and !overflow_flag) |=> !ovf_clear) else $error("clear without overflow");
  AST_NO_CLEAR_ZERO: assert property (@(posedge clk) disable iff (rst)
    (s_start and is_zero) |=> !ovf_clear) else $error("spurious clear");
  // Auxiliary register and pointer
  AST_NO_MOD: assert property (@(posedge clk) disable iff (rst)
    (s_start and !instr_word[`CBU_IND_BIT]) |=> !aux_write && !ptr_write) else $error("spurious aux update");
  AST_PTR_VALUE: assert property (@(posedge clk) disable iff (rst)
    (s_start and instr_word[`CBU_IND_BIT] and instr_word[`CBU_PTR_UPD_BIT])
    |=> ptr_write && ptr_out == $past(instr_word[2:0])) else $error("pointer update wrong");
  AST_AUX_STEP: assert property (@(posedge clk) disable iff (rst)
    (s_start and instr_word[`CBU_IND_BIT] and (modf == 3'h2)) |=> aux_write && aux_sel == $past(aux_reg_pointer)
    && aux_out == 16'($past(aux_register) + 16'h0001)) else $error("aux step wrong");
  // Timing and refusal
  AST_TWO_CYCLE: assert property (@(posedge clk) disable iff (rst)
    (s_start and !cond) |=> s_finish_short) else $error("not-taken timing wrong");
  AST_RAM_CYCLE: assert property (@(posedge clk) disable iff (rst)
    (s_start and cond and (target_kind == MEM_RAM)) |=> s_finish_short) else $error("ram timing wrong");
  AST_ROM_CYCLE: assert property (@(posedge clk) disable iff (rst)
    (s_start and cond and (target_kind == MEM_ROM)) |=> s_finish_rom) else $error("rom timing wrong");
  AST_BUSY_SET: assert property (@(posedge clk) disable iff (rst)
    s_start |=> busy && !done) else $error("busy not raised");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (rst)
    done |=> !done && !pc_load) else $error("done longer than one cycle");
  AST_REPEAT: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_IDLE && instr_valid && is_zero && repeat_active |=> illegal_repeat && !busy) else $error("repeat accepted");
  AST_REFUSE_QUIET: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_IDLE && instr_valid && (is_zero || is_ovf) && repeat_active
    |=> !aux_write && !ptr_write && !ovf_clear && !pc_load) else $error("refused branch had effects");
endmodule

//--- testbench/prog_mem.sv
// Program memory model holding the two-word branch test program
`timescale 1ns/1ps
module prog_mem (
  // Fetch address
  input wire logic [15:0] addr,
  // Both words of the instruction at addr
  output logic [15:0] instr_word,
  output logic [15:0] target_word
);
  // Fixed program; unmapped words read as the inverted address so nothing stale shows
  function automatic logic [15:0] rd(input logic [15:0] a);
    case (a)
      16'h0010: rd = 16'hf600;
      16'h0011: rd = 16'hffff; // Top of program space
      16'h0020: rd = 16'hf000;
      16'h0021: rd = 16'h1234;
      16'h0030: rd = 16'hf6a9; // Indirect, increment, new pointer 1
      16'h0031: rd = 16'h0040;
      default: rd = ~a;
    endcase
  endfunction
  // Second word fetched from the next address, delivered with the first
  assign instr_word = rd(addr);
  assign target_word = rd(addr + 16'h0001);
endmodule

//--- testbench/tb.sv
// Self-checking bench for the conditional branch unit
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
  logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, repeat_active = 1'b0, overflow_flag = 1'b0;
  logic [1:0] target_kind = 2'h0;
  logic [15:0] pc_in = 16'h0000, aux_register = 16'h0005, instr_word, target_word, pc_out, aux_out;
  logic [31:0] accumulator = 32'h00000000;
  logic [2:0] aux_reg_pointer = 3'h3, aux_sel, ptr_out;
  logic busy, done, illegal_repeat, pc_load, taken, ovf_clear, aux_write, ptr_write;
  logic sc, sa, sp, si, sb;
  int k, miscompares = 0, n_compared = 0;
  // 125 MHz core clock
  always #4 clk = ~clk;
  prog_mem PM (.addr(pc_in), .instr_word(instr_word), .target_word(target_word));
  conditional_branch_unit DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .target_word(target_word), .repeat_active(repeat_active), .target_kind(target_kind), .pc_in(pc_in),
    .accumulator(accumulator), .overflow_flag(overflow_flag), .aux_reg_pointer(aux_reg_pointer),
    .aux_register(aux_register), .busy(busy), .done(done), .illegal_repeat(illegal_repeat),
    .pc_load(pc_load), .pc_out(pc_out), .taken(taken), .ovf_clear(ovf_clear), .aux_write(aux_write),
    .aux_out(aux_out), .aux_sel(aux_sel), .ptr_write(ptr_write), .ptr_out(ptr_out));
  // One request; k counts falling edges until done, pulses are gathered on the way
  task automatic go(input logic [15:0] pc, input logic [31:0] accum, input logic ovf, input logic [1:0] kd,
    input logic rp);
    pc_in = pc;
    accumulator = accum;
    overflow_flag = ovf;
    target_kind = kd;
    repeat_active = rp;
    instr_valid = 1'b1;
    {sc, sa, sp, si} = 4'h0;
    @(negedge clk);
    instr_valid = 1'b0;
    for (k = 1; k < 9; k++) begin
      if (k == 1) sb = busy;
      {sc, sa, sp, si} = {sc | ovf_clear, sa | aux_write, sp | ptr_write, si | illegal_repeat};
      if (done === 1'b1) break;
      @(negedge clk);
    end
  endtask
  task automatic t_zero_taken;
    go(16'h0010, 32'h00000000, 1'b0, 2'h0, 1'b0);
    `CHK(pc_out, 16'hffff)
    `CHK(taken, 1'b1)
    `CHK(k, 3)
    `CHK({sa, sp}, 2'h0)
    `CHK({sb, busy, pc_load}, 3'h5)
    $display("zero branch taken finished");
  endtask
  task automatic t_zero_not;
    go(16'h0010, 32'h80000000, 1'b0, 2'h1, 1'b0);
    `CHK(pc_out, 16'h0012)
    `CHK(taken, 1'b0)
    `CHK(k, 3)
    $display("zero branch not taken finished");
  endtask
  task automatic t_ovf;
    go(16'h0020, 32'h00000001, 1'b1, 2'h1, 1'b0);
    `CHK(pc_out, 16'h1234)
    `CHK(sc, 1'b1)
    `CHK(k, 4)
    `CHK({sb, busy, pc_load}, 3'h5)
    go(16'h0020, 32'h00000000, 1'b0, 2'h2, 1'b0);
    `CHK(pc_out, 16'h0022)
    `CHK(sc, 1'b0)
    $display("overflow branch finished");
  endtask
  task automatic t_aux_ext;
    go(16'h0030, 32'h00000000, 1'b0, 2'h2, 1'b0);
    `CHK(pc_out, 16'h0040)
    `CHK(k, 5)
    `CHK({sa, sp, aux_sel, ptr_out}, 8'hd9)
    `CHK(aux_out, 16'h0006)
    $display("indirect update finished");
  endtask
  task automatic t_repeat;
    go(16'h0010, 32'h00000000, 1'b0, 2'h0, 1'b1);
    `CHK({si, sa, k == 9}, 3'h5)
    `CHK({sb, pc_load}, 2'h0)
    repeat_active = 1'b0;
    $display("repeat refusal finished");
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence after three reset cycles
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_zero_taken();
    t_zero_not();
    t_ovf();
    t_aux_ext();
    t_repeat();
    report_and_stop();
  end
  // Watchdog well beyond the few dozen cycles the tests need
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
endmodule
